/* File: hw/upm_map.vh */
// Constants of the uplink port pin multiplexer: strap codes, register map, timing.
// Assumes inclusion by the upm design and testbench files.
`ifndef UPM_MAP_VH
`define UPM_MAP_VH
// Interface strap codes
`define UPM_MODE_MII          2'h0
`define UPM_MODE_RMII         2'h1
`define UPM_MODE_GMII         2'h2
`define UPM_MODE_RGMII        2'h3
`define UPM_MODE_RST          2'h3
// Configuration register offset and field
`define UPM_REG_CFG86         8'h56
`define UPM_REG_STATUS        8'h57
`define UPM_CFG_CLKSEL_BIT    7
`define UPM_CFG_OVR_BIT       6
`define UPM_CFG_RST           8'h00
// Reference clock divider: last count of each half period of the 50 MHz clock, in system cycles
`define UPM_REFDIV_HALF       4'h1
`define UPM_ROLE_RST          1'b1
`endif

/* File: hw/upm_sync.v */
// Two-flop synchroniser for a bus of pin-level inputs.
// Assumes inputs are asynchronous to i_mclk.
`timescale 1ns/100ps
module upm_sync #(
    parameter W = 1
) (
    input  wire         i_mclk,   // System clock
    input  wire         i_rstn,   // Async reset, active low
    input  wire [W-1:0] i_d,      // Asynchronous input
    output wire [W-1:0] o_q       // Synchronised output
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // First flop feeds only the second
    always @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= i_d;
            sync_q <= meta_q;
        end
    end
    assign o_q = sync_q;
endmodule // upm_sync

/* File: hw/upm_edge.v */
// Edge finder for a synchronised clock pin.
// Assumes i_lvl is already in the i_mclk domain.
`timescale 1ns/100ps
module upm_edge (
    input  wire i_mclk,   // System clock
    input  wire i_rstn,   // Async reset, active low
    input  wire i_lvl,    // Synchronised level
    output wire o_rise,   // One-cycle pulse on rising edge
    output wire o_fall    // One-cycle pulse on falling edge
);
    reg last_q;

    // Previous level for edge detection
    always @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            last_q <= 1'b0;
        end else begin
            last_q <= i_lvl;
        end
    end
    assign o_rise = i_lvl & ~last_q;
    assign o_fall = ~i_lvl & last_q;
endmodule // upm_edge

/* File: hw/upm_pin_mux.v */
// Uplink port pin multiplexer: strap capture, lane gating, clock pin direction.
// Assumes pins pass through pad cells; output enables are active low (0 = drive).
// Summary of operation
// - Two strap bits pick MII, RMII, GMII or RGMII; RGMII by default.
// - Transmit enable input means enable, or transmit control in RGMII.
// - Transmit lanes 0-1 always, 2-3 except RMII, 4-7 only GMII.
// - Receive lanes 0-1 always, 2-3 except RMII, 4-7 only GMII.
// - Transmit error honoured only in GMII and MII.
// - Receive error driven only in GMII and MII.
// - Carrier sense and collision active only in GMII and MII.
// - Receive valid is valid, combined carrier/valid, or RGMII control.
// - Receive clock pin driven in GMII, RGMII, RMII clock mode and MII PHY role.
// - RGMII transmit data taken on both edges of the transmit clock.
// - MII clocks are outputs in PHY role, inputs in MAC role.
// - Role strap high gives MAC role, low gives PHY role.
// - GMII PHY role drives carrier and collision; MII PHY also clocks.
// - RMII role strap high is clock mode, low is normal mode.
// - Config register bit 7 may override the RMII clock choice.
// - Strap pins are inputs during reset and outputs afterwards.
// - Straps are sampled during reset to set the modes.
`timescale 1ns/100ps
`include "upm_map.vh"
module upm_pin_mux (
    // Clock and reset
    input  wire       i_mclk,                 // System clock, 40 MHz
    input  wire       i_rstn,                 // Async reset, active low

    // Strap pins and their LED drive
    input  wire       i_iface_strap_hi,       // Interface strap bit 1 pin level
    input  wire       i_iface_strap_lo,       // Interface strap bit 0 pin level
    input  wire       i_role_clock_strap,     // Role / RMII clock strap pin level
    input  wire       i_led_hi,               // LED level for strap pin bit 1
    input  wire       i_led_lo,               // LED level for strap pin bit 0
    input  wire       i_led_role,             // LED level for role strap pin
    output reg        o_strap_oen_n,          // Strap pins: 1 = input with pull-up
    output reg  [2:0] o_strap_out,            // Strap pins LED drive

    // Transmit pins from the far side
    input  wire       i_uplink_tx_enable_ctl, // Transmit enable / control pin
    input  wire [7:0] i_uplink_tx_data,       // Transmit data pins
    input  wire       i_uplink_tx_error,      // Transmit error pin
    input  wire       i_uplink_tx_clock,      // Transmit clock pin input
    output reg        o_uplink_tx_clock,      // Transmit clock pin drive
    output reg        o_uplink_tx_clock_oen_n,// Transmit clock enable, 0 = drive

    // Receive clock pin
    input  wire       i_uplink_rx_clock,      // Receive clock pin input
    output reg        o_uplink_rx_clock,      // Receive clock pin drive
    output reg        o_uplink_rx_clock_oen_n,// Receive clock enable, 0 = drive

    // Receive side of the core
    input  wire [7:0] i_core_rx_data,         // Core receive data
    input  wire       i_core_rx_valid,        // Core receive valid or control
    input  wire       i_core_rx_error,        // Core receive error
    input  wire       i_core_crs,             // Core carrier sense, PHY role
    input  wire       i_core_col,             // Core collision, PHY role
    input  wire       i_core_mii_clk,         // Core MII clock level, PHY role

    // Receive pins
    output reg  [7:0] o_uplink_rx_data,       // Receive data pins
    output reg  [7:0] o_uplink_rx_data_oen_n, // Receive data enables, 0 = drive
    output reg        o_uplink_rx_valid_ctl,  // Receive valid / control pin
    output reg        o_uplink_rx_error,      // Receive error pin
    output reg        o_uplink_rx_error_oen_n,// Receive error enable, 0 = drive

    // Carrier sense and collision pins
    input  wire       i_uplink_carrier_sense, // Carrier sense pin input
    input  wire       i_uplink_collision,     // Collision pin input
    output reg        o_uplink_carrier_sense, // Carrier sense pin drive
    output reg        o_uplink_collision,     // Collision pin drive
    output reg        o_uplink_cc_oen_n,      // Carrier/collision enable, 0 = drive

    // Transmit side of the core
    output reg        o_core_tx_en,           // Gated transmit enable
    output reg        o_core_tx_ctl,          // RGMII transmit control
    output reg  [7:0] o_core_tx_data,         // Gated transmit data
    output reg        o_core_tx_error,        // Gated transmit error
    output reg        o_core_crs,             // Carrier sense seen from pin, MAC role
    output reg        o_core_col,             // Collision seen from pin, MAC role

    // Captured configuration
    output reg  [1:0] o_mode,                 // Captured interface mode
    output reg        o_uplink_gig_mac,       // MAC role selected
    output reg        o_rmii_int_clk,         // RMII internal clock in use

    // Register port
    input  wire [7:0] i_reg_addr,             // Register address
    input  wire [7:0] i_reg_wdata,            // Register write data
    input  wire       i_reg_wr,               // Register write strobe
    input  wire       i_reg_rd,               // Register read strobe
    output reg  [7:0] o_reg_rdata             // Register read data, next cycle
);
    // Synchronised pin levels
    wire [2:0] strap_s;
    wire [3:0] pin_s;
    wire       txc_rise;
    wire       txc_fall;
    wire       rxc_rise;
    wire       rxc_fall;
    reg  [1:0] mode_q;
    reg        role_q;
    reg        cfg_clk_q;
    reg        cfg_ovr_q;
    reg        run_q;
    reg  [3:0] div_q;
    reg        ref_q;
    reg        gig_d;
    reg        ten_d;
    reg        rmii_int_d;
    reg  [7:0] lane_mask;

    // The strap synchroniser is never reset: it samples the pins all through
    // reset, so its output already holds the strap levels when reset ends.
    upm_sync #(.W(3)) u_strap_sync (
        .i_mclk (i_mclk),
        .i_rstn (1'b1),
        .i_d    ({i_iface_strap_hi, i_iface_strap_lo, i_role_clock_strap}),
        .o_q    (strap_s)
    );
    upm_sync #(.W(4)) u_pin_sync (
        .i_mclk (i_mclk),
        .i_rstn (i_rstn),
        .i_d    ({i_uplink_tx_clock, i_uplink_rx_clock, i_uplink_carrier_sense, i_uplink_collision}),
        .o_q    (pin_s)
    );
    upm_edge u_txc_edge (
        .i_mclk (i_mclk),
        .i_rstn (i_rstn),
        .i_lvl  (pin_s[3]),
        .o_rise (txc_rise),
        .o_fall (txc_fall)
    );
    upm_edge u_rxc_edge (
        .i_mclk (i_mclk),
        .i_rstn (i_rstn),
        .i_lvl  (pin_s[2]),
        .o_rise (rxc_rise),
        .o_fall (rxc_fall)
    );

    // Lane mask per mode, used for both directions
    function [7:0] lanes;
        input [1:0] m;
        begin
            case (m)
                `UPM_MODE_GMII: lanes = 8'hff;
                `UPM_MODE_RMII: lanes = 8'h03;
                default:        lanes = 8'h0f;
            endcase
        end
    endfunction

    // Strap capture: pads float high through pull-ups while the latch is open.
    // The straps must be steady for two clocks before release; the first
    // clocked cycle then closes the latch, before the pins turn to LED drive.
    // A later change on the pins cannot move the mode until the next reset.
    always @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            mode_q <= `UPM_MODE_RST;
            role_q <= `UPM_ROLE_RST;
            run_q  <= 1'b0;
        end else if (!run_q) begin
            mode_q <= strap_s[2:1];
            role_q <= strap_s[0];
            run_q  <= 1'b1;
        end
    end

    // Configuration register; writes are ignored elsewhere
    // Bit 6 enables the override; without it the role strap picks the clock
    always @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            cfg_clk_q <= 1'b0;
            cfg_ovr_q <= 1'b0;
        end else if (i_reg_wr && i_reg_addr == `UPM_REG_CFG86) begin
            cfg_clk_q <= i_reg_wdata[`UPM_CFG_CLKSEL_BIT];
            cfg_ovr_q <= i_reg_wdata[`UPM_CFG_OVR_BIT];
        end
    end

    // Mode decode; mode and role are frozen once run_q is set
    // gig_d marks the modes whose receive clock is always driven
    always @* begin
        gig_d      = (mode_q == `UPM_MODE_GMII) || (mode_q == `UPM_MODE_RGMII);
        ten_d      = (mode_q == `UPM_MODE_GMII) || (mode_q == `UPM_MODE_MII);
        rmii_int_d = cfg_ovr_q ? cfg_clk_q : role_q;
        lane_mask  = lanes(mode_q);
    end

    // 50 MHz reference is approximated at i_mclk/4; a real part uses a PLL
    // Limitation: the stand-in runs at a quarter of i_mclk, not at pin rate
    always @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            div_q <= 4'h0;
            ref_q <= 1'b0;
        end else if (div_q == `UPM_REFDIV_HALF) begin
            div_q <= 4'h0;
            ref_q <= ~ref_q;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end

    // Transmit path: capture on clock edges; RGMII takes both edges
    // Data pins are not synchronised: they are steady around the clock edge
    always @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_core_tx_en    <= 1'b0;
            o_core_tx_ctl   <= 1'b0;
            o_core_tx_data  <= 8'h00;
            o_core_tx_error <= 1'b0;
        end else if (txc_rise || (mode_q == `UPM_MODE_RGMII && txc_fall)) begin
            o_core_tx_en    <= (mode_q != `UPM_MODE_RGMII) & i_uplink_tx_enable_ctl;
            o_core_tx_ctl   <= (mode_q == `UPM_MODE_RGMII) & i_uplink_tx_enable_ctl;
            o_core_tx_data  <= i_uplink_tx_data & lane_mask;
            o_core_tx_error <= ten_d & i_uplink_tx_error;
        end
    end

    // Receive path and pin directions
    // All pins stay undriven until the straps are latched
    always @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_uplink_rx_data        <= 8'h00;
            o_uplink_rx_data_oen_n  <= 8'hff;
            o_uplink_rx_valid_ctl   <= 1'b0;
            o_uplink_rx_error       <= 1'b0;
            o_uplink_rx_error_oen_n <= 1'b1;
            o_uplink_carrier_sense  <= 1'b0;
            o_uplink_collision      <= 1'b0;
            o_uplink_cc_oen_n       <= 1'b1;
            o_uplink_tx_clock       <= 1'b0;
            o_uplink_tx_clock_oen_n <= 1'b1;
            o_uplink_rx_clock       <= 1'b0;
            o_uplink_rx_clock_oen_n <= 1'b1;
            o_core_crs              <= 1'b0;
            o_core_col              <= 1'b0;
        end else if (run_q) begin
            o_uplink_rx_data        <= i_core_rx_data & lane_mask;
            o_uplink_rx_data_oen_n  <= ~lane_mask;
            o_uplink_rx_valid_ctl   <= i_core_rx_valid;
            o_uplink_rx_error       <= ten_d & i_core_rx_error;
            o_uplink_rx_error_oen_n <= ~ten_d;
            o_uplink_carrier_sense  <= ten_d & ~role_q & i_core_crs;
            o_uplink_collision      <= ten_d & ~role_q & i_core_col;
            o_uplink_cc_oen_n       <= ~(ten_d & ~role_q);
            o_core_crs              <= ten_d & role_q & pin_s[1];
            o_core_col              <= ten_d & role_q & pin_s[0];
            // Transmit clock driven only by an MII PHY; else far side drives it
            o_uplink_tx_clock       <= i_core_mii_clk;
            o_uplink_tx_clock_oen_n <= ~(mode_q == `UPM_MODE_MII && !role_q);
            case (mode_q)
                `UPM_MODE_MII: begin
                    o_uplink_rx_clock       <= i_core_mii_clk;
                    o_uplink_rx_clock_oen_n <= role_q;
                end
                `UPM_MODE_RMII: begin
                    o_uplink_rx_clock       <= ref_q;
                    o_uplink_rx_clock_oen_n <= ~rmii_int_d;
                end
                default: begin
                    o_uplink_rx_clock       <= ref_q;
                    o_uplink_rx_clock_oen_n <= ~gig_d;
                end
            endcase
        end
    end

    // Strap pins: released to input during reset, LED drive afterwards
    always @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_strap_oen_n <= 1'b1;
            o_strap_out   <= 3'h0;
        end else begin
            o_strap_oen_n <= ~run_q;
            o_strap_out   <= {i_led_hi, i_led_lo, i_led_role};
        end
    end

    // Status outputs and register reads; unmapped reads give zero
    // Status reads show the live selections, override included
    always @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_mode           <= `UPM_MODE_RST;
            o_uplink_gig_mac <= `UPM_ROLE_RST;
            o_rmii_int_clk   <= 1'b0;
            o_reg_rdata      <= 8'h00;
        end else begin
            o_mode           <= mode_q;
            o_uplink_gig_mac <= role_q;
            o_rmii_int_clk   <= (mode_q == `UPM_MODE_RMII) & rmii_int_d;
            if (i_reg_rd && i_reg_addr == `UPM_REG_CFG86) begin
                o_reg_rdata <= {cfg_clk_q, cfg_ovr_q, 6'h00};
            end else if (i_reg_rd && i_reg_addr == `UPM_REG_STATUS) begin
                o_reg_rdata <= {4'h0, rmii_int_d, role_q, mode_q};
            end else begin
                o_reg_rdata <= 8'h00;
            end
        end
    end
    // Receive clock edges are kept for a later RGMII loop check
    wire unused_rxc = rxc_rise | rxc_fall;
endmodule // upm_pin_mux

/* File: testbench/upm_far_end.sv */
// Far end of the uplink: host MAC or external PHY driving the transmit pins.
// Assumes the bench sets the frame contents before a frame and holds them through it.
`timescale 1ns/100ps
module upm_far_end (
    input  wire logic       i_frame, // Frame in progress
    input  wire logic [7:0] i_data,  // Byte for the lanes
    input  wire logic       i_en,    // Enable or control level
    input  wire logic       i_err,   // Error level
    output      logic       o_clk,   // Transmit clock
    output      logic [7:0] o_data,  // Transmit lanes
    output      logic       o_en,    // Transmit enable or control
    output      logic       o_err    // Transmit error
);
    // 200 ns link clock, started by a frame, runs out the period in progress when the frame ends; odd start keeps it off the system clock edges
    initial o_clk = 1'b0;
    always begin
        wait (i_frame);
        #13;
        while (i_frame) begin
            #100 o_clk = 1'b1;
            #100 o_clk = 1'b0;
        end
    end
    // Held over both edges of every period inside the frame; released pins fall to the pad pull-downs
    assign o_data = i_frame ? i_data : 8'h00;
    assign o_en   = i_frame & i_en;
    assign o_err  = i_frame & i_err;
endmodule // upm_far_end

/* File: testbench/upm_pin_mux_assertions.sv */
// Checker of the uplink pin multiplexer: lane gating, pin direction, frozen straps.
// Assumes one clock domain and a bind to the design's top module.
`timescale 1ns/100ps
`include "upm_map.vh"
module upm_pin_mux_assertions (
    input wire logic       i_mclk,                  // Clock
    input wire logic       i_rstn,                  // Reset
    input wire logic       o_strap_oen_n,           // Strap direction
    input wire logic [7:0] i_core_rx_data,          // Core rx data
    input wire logic       i_core_rx_valid,         // Core rx valid
    input wire logic [7:0] o_uplink_rx_data,        // Rx lanes
    input wire logic [7:0] o_uplink_rx_data_oen_n,  // Rx lane enables
    input wire logic       o_uplink_rx_valid_ctl,   // Rx valid pin
    input wire logic       o_uplink_rx_error_oen_n, // Rx error enable
    input wire logic       o_uplink_cc_oen_n,       // Carrier enable
    input wire logic       o_uplink_tx_clock_oen_n, // Tx clock enable
    input wire logic       o_uplink_rx_clock_oen_n, // Rx clock enable
    input wire logic [7:0] o_core_tx_data,          // Gated tx data
    input wire logic [1:0] o_mode,                  // Captured mode
    input wire logic       o_uplink_gig_mac         // MAC role
);
    logic [1:0] up_q; // Edges since release, saturating
    logic       run;  // Outputs follow the captured straps
    logic [7:0] lane; // Lanes of the captured mode
    // Straps land on the first edge, reach the outputs on the second
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn)
            up_q <= 2'h0;
        else if (up_q != 2'h3)
            up_q <= up_q + 2'h1;
    end
    assign run  = (up_q == 2'h3);
    assign lane = (o_mode == `UPM_MODE_GMII) ? 8'hff : (o_mode == `UPM_MODE_RMII) ? 8'h03 : 8'h0f;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    // Pin functions must not move during operation
    chk_straps_frozen: assert property (run |=> $stable(o_mode) && $stable(o_uplink_gig_mac))
        else $error("mode moved");
    chk_rx_mask: assert property (run |-> o_uplink_rx_data_oen_n == ~lane) else $error("rx enables");
    chk_rx_follow: assert property (run |=> o_uplink_rx_data == ($past(i_core_rx_data) & lane))
        else $error("rx lanes");
    chk_rx_valid: assert property (run |=> o_uplink_rx_valid_ctl == $past(i_core_rx_valid))
        else $error("rx valid");
    chk_rx_err_off: assert property (run && o_mode[0] |-> o_uplink_rx_error_oen_n) else $error("rx error");
    chk_cc_dir: assert property (run |-> o_uplink_cc_oen_n == (o_mode[0] || o_uplink_gig_mac))
        else $error("carrier dir");
    chk_tx_lanes: assert property (run |-> (o_core_tx_data & ~lane) == 8'h00) else $error("tx lanes");
    chk_rxclk_dir: assert property (run && o_mode != `UPM_MODE_RMII |->
        o_uplink_rx_clock_oen_n == ((o_mode == `UPM_MODE_MII) && o_uplink_gig_mac)) else $error("rx clock dir");
    chk_txclk_dir: assert property (run |->
        o_uplink_tx_clock_oen_n == !(o_mode == `UPM_MODE_MII && !o_uplink_gig_mac)) else $error("tx clock dir");
    chk_strap_dir: assert property (disable iff (1'b0) (i_rstn ? (!run || !o_strap_oen_n) : o_strap_oen_n))
        else $error("strap dir");
    cov_gmii: cover property (run && o_mode == `UPM_MODE_GMII);
    cov_rmii_clk: cover property (run && o_mode == `UPM_MODE_RMII && !o_uplink_rx_clock_oen_n);
    cov_phy: cover property (run && !o_uplink_gig_mac && !o_mode[0]);
endmodule // upm_pin_mux_assertions
bind upm_pin_mux upm_pin_mux_assertions upm_pin_mux_assertions_i (.i_mclk, .i_rstn, .o_strap_oen_n,
    .i_core_rx_data, .i_core_rx_valid, .o_uplink_rx_data, .o_uplink_rx_data_oen_n, .o_uplink_rx_valid_ctl,
    .o_uplink_rx_error_oen_n, .o_uplink_cc_oen_n, .o_uplink_tx_clock_oen_n, .o_uplink_rx_clock_oen_n,
    .o_core_tx_data, .o_mode, .o_uplink_gig_mac);

/* File: testbench/upm_pin_mux_tb.sv */
// Bench of the uplink pin multiplexer: all modes and roles, lanes, pin direction, registers.
// Assumes the far-end model and the bound checker; pads are resolved here from the enables.
`timescale 1ns/100ps
`include "upm_map.vh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module upm_pin_mux_tb;
    int         err_count   = 0;
    int         comparisons = 0;
    logic       i_mclk      = 1'b0;
    logic       i_rstn      = 1'b1;  // Falls at time 0 so reset acts at once
    logic       i_reg_wr    = 1'b0;
    logic       i_reg_rd    = 1'b0;
    logic       lvl         = 1'b0;  // Level on the one-bit data inputs
    logic       frame       = 1'b0;
    logic [2:0] strap       = 3'h7;  // External strap resistors
    logic [2:0] led         = 3'h0;
    logic [7:0] pat         = 8'h00;
    logic [7:0] i_reg_addr  = 8'h00;
    logic [7:0] i_reg_wdata = 8'h00;
    wire        o_strap_oen_n, o_uplink_tx_clock, o_uplink_tx_clock_oen_n, o_uplink_rx_clock, o_uplink_rx_clock_oen_n;
    wire        o_uplink_rx_valid_ctl, o_uplink_rx_error, o_uplink_rx_error_oen_n, o_uplink_carrier_sense;
    wire        o_uplink_collision, o_uplink_cc_oen_n, o_core_tx_en, o_core_tx_ctl, o_core_tx_error, o_core_crs;
    wire        o_core_col, o_uplink_gig_mac, o_rmii_int_clk, f_clk, f_en, f_err;
    wire  [1:0] o_mode;
    wire  [2:0] o_strap_out;
    wire  [7:0] o_uplink_rx_data, o_uplink_rx_data_oen_n, o_core_tx_data, o_reg_rdata, f_data;
    wire  [2:0] pin = o_strap_oen_n ? strap : o_strap_out; // LED drive after reset must not re-strap
    initial forever #12.5 i_mclk = ~i_mclk;
    upm_far_end upm_far_end_i (.i_frame(frame), .i_data(pat), .i_en(lvl), .i_err(lvl),
        .o_clk(f_clk), .o_data(f_data), .o_en(f_en), .o_err(f_err));
    // Two-way pads: the device's enable wins, else the far end or the bench drives
    upm_pin_mux upm_pin_mux_i (.i_mclk, .i_rstn, .i_iface_strap_hi(pin[2]), .i_iface_strap_lo(pin[1]),
        .i_role_clock_strap(pin[0]), .i_led_hi(led[2]), .i_led_lo(led[1]), .i_led_role(led[0]), .o_strap_oen_n,
        .o_strap_out, .i_uplink_tx_enable_ctl(f_en), .i_uplink_tx_data(f_data), .i_uplink_tx_error(f_err),
        .i_uplink_tx_clock(o_uplink_tx_clock_oen_n ? f_clk : o_uplink_tx_clock), .o_uplink_tx_clock,
        .o_uplink_tx_clock_oen_n, .i_uplink_rx_clock(o_uplink_rx_clock_oen_n ? f_clk : o_uplink_rx_clock),
        .o_uplink_rx_clock, .o_uplink_rx_clock_oen_n, .i_core_rx_data(pat), .i_core_rx_valid(lvl),
        .i_core_rx_error(lvl), .i_core_crs(lvl), .i_core_col(lvl), .i_core_mii_clk(f_clk), .o_uplink_rx_data,
        .o_uplink_rx_data_oen_n, .o_uplink_rx_valid_ctl, .o_uplink_rx_error, .o_uplink_rx_error_oen_n,
        .i_uplink_carrier_sense(o_uplink_cc_oen_n ? lvl : o_uplink_carrier_sense),
        .i_uplink_collision(o_uplink_cc_oen_n ? lvl : o_uplink_collision), .o_uplink_carrier_sense,
        .o_uplink_collision, .o_uplink_cc_oen_n, .o_core_tx_en, .o_core_tx_ctl, .o_core_tx_data, .o_core_tx_error,
        .o_core_crs, .o_core_col, .o_mode, .o_uplink_gig_mac, .o_rmii_int_clk, .i_reg_addr, .i_reg_wdata,
        .i_reg_wr, .i_reg_rd, .o_reg_rdata);
    function automatic logic [7:0] lanes(input logic [1:0] m);
        return (m == `UPM_MODE_GMII) ? 8'hff : (m == `UPM_MODE_RMII) ? 8'h03 : 8'h0f;
    endfunction
    // Register bus cycles; each strobe is one cycle long
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_mclk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_mclk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_mclk);
        i_reg_rd <= 1'b0;
        #1;
        `CHK(o_reg_rdata, e)
    endtask
    // Six cycles of reset with the given straps, LEDs set opposite to expose re-strapping
    task automatic do_reset(input logic [2:0] s);
        i_rstn <= 1'b0;
        strap <= s;
        led <= ~s;
        repeat (5) @(posedge i_mclk);
        #1;
        `CHK({o_strap_oen_n, o_mode, o_uplink_gig_mac}, 4'hf)
        @(posedge i_mclk);
        i_rstn <= 1'b1;
        repeat (3) @(posedge i_mclk);
        #1;
        `CHK({o_strap_oen_n, o_strap_out}, {1'b0, ~s})
    endtask
    // One strap setting: directions, rx lanes, then one frame from the far end
    task automatic t_mode(input logic [1:0] m, input logic r);
        logic [7:0] ln;
        logic       gm;
        logic       v;
        ln = lanes(m);
        gm = !m[0];
        do_reset({m, r});
        `CHK({o_mode, o_uplink_gig_mac}, {m, r})
        `CHK(o_uplink_rx_data_oen_n, ~ln)
        `CHK(o_uplink_rx_error_oen_n, !gm)
        `CHK(o_uplink_cc_oen_n, !(gm && !r))
        `CHK(o_uplink_tx_clock_oen_n, !(m == `UPM_MODE_MII && !r))
        `CHK(o_uplink_rx_clock_oen_n, m == `UPM_MODE_MII ? r : m == `UPM_MODE_RMII ? !r : 1'b0)
        @(posedge i_mclk);
        pat <= 8'hff;
        lvl <= 1'b1;
        repeat (4) @(posedge i_mclk);
        #1;
        `CHK({o_uplink_rx_data, o_uplink_rx_valid_ctl, o_uplink_rx_error}, {ln, 1'b1, gm})
        `CHK({o_uplink_carrier_sense, o_uplink_collision, o_core_crs, o_core_col}, {{2{gm && !r}}, {2{gm && r}}})
        v = o_uplink_rx_clock;
        repeat (2) @(posedge i_mclk);
        #1;
        `CHK(o_uplink_rx_clock, (m == `UPM_MODE_MII) ? v : !v)
        @(posedge i_mclk);
        frame <= 1'b1;
        @(posedge f_clk);
        repeat (2) @(posedge i_mclk);
        #1;
        `CHK(o_uplink_tx_clock, 1'b1)
        repeat (3) @(posedge i_mclk);
        #1;
        `CHK({o_core_tx_data, o_core_tx_error}, {ln, gm})
        `CHK({o_core_tx_en, o_core_tx_ctl}, m == `UPM_MODE_RGMII ? 2'h1 : 2'h2)
        @(posedge i_mclk);
        frame <= 1'b0;
        lvl <= 1'b0;
        pat <= 8'h00;
        $display("mode %0d role %0d done", m, r);
    endtask
    // RMII normal mode, then the register picks the internal clock and then the external one, override left on
    task automatic t_regs;
        do_reset({`UPM_MODE_RMII, 1'b0});
        `CHK({o_rmii_int_clk, o_uplink_rx_clock_oen_n}, 2'h1)
        reg_wr(`UPM_REG_CFG86, 8'hc0);
        reg_rd(`UPM_REG_CFG86, 8'hc0);
        reg_rd(`UPM_REG_STATUS, 8'h09);
        `CHK({o_rmii_int_clk, o_uplink_rx_clock_oen_n}, 2'h2)
        reg_wr(8'h10, 8'hff);
        reg_rd(8'h10, 8'h00);
        reg_wr(`UPM_REG_STATUS, 8'hff);
        reg_rd(`UPM_REG_STATUS, 8'h09);
        reg_wr(`UPM_REG_CFG86, 8'h40);
        reg_rd(`UPM_REG_STATUS, 8'h01);
        `CHK(o_uplink_rx_clock_oen_n, 1'b1)
        $display("register test done");
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence: every strap code in both roles
    initial begin
        for (int k = 0; k < 8; k++)
            t_mode(k[2:1], k[0]);
        t_regs;
        end_of_test;
    end
    // Whole run needs well under 20 us
    initial begin
        #100000;
        err_count++;
        $display("CHECK FAILED t=%0t watchdog", $time);
        end_of_test;
    end
endmodule // upm_pin_mux_tb
